/* hw/key_scan_map.svh */
// Purpose: register offsets, field positions, reset values and timing counts of the key scanner
// Assumes: 32-bit register port with word-aligned byte offsets
// Notes:   definitions only
`ifndef KEY_SCAN_MAP_SVH
`define KEY_SCAN_MAP_SVH

`define KS_OFF_CTRL        8'h00
`define KS_OFF_STATUS      8'h04
`define KS_OFF_KEY         8'h08

`define KS_CTRL_EN_BIT     0
`define KS_CTRL_COLS_LSB   8
`define KS_CTRL_COLS_MSB   12
`define KS_CTRL_ROWS_LSB   16
`define KS_CTRL_ROWS_MSB   19

`define KS_ST_GHOST_BIT    0
`define KS_ST_OVF_BIT      1
`define KS_ST_AVAIL_BIT    2
`define KS_ST_REQ_BIT      3
`define KS_ST_CNT_LSB      8
`define KS_ST_CNT_MSB      12
`define KS_KEY_VALID_BIT   8

`define KS_RST_EN          1'b0
`define KS_RST_COLS        5'h14
`define KS_RST_ROWS        4'h8
`define KS_MAX_COLS        5'h14
`define KS_MAX_ROWS        4'h8

`define KS_SYS_CLK_HZ      25000000
`define KS_SCAN_CLK_HZ     128000
`define KS_SCAN_DIV        (`KS_SYS_CLK_HZ / `KS_SCAN_CLK_HZ)
`define KS_FILTER_CYC      8

`endif

/* hw/key_scan_pkg.sv */
// Purpose: shared types of the key scanner
// Assumes: nothing
// Notes:   constants live in key_scan_map.svh
package key_scan_pkg;
	typedef enum logic [1:0] {ST_IDLE, ST_SCAN, ST_SCAN_END} scan_state_t;
endpackage : key_scan_pkg

/* hw/row_filter.sv */
// Purpose: synchronise and glitch-filter one row input
// Assumes: raw input is asynchronous to clk
// Notes:   output changes only after the input holds steady for FILT cycles
`timescale 1ns/10ps
module row_filter #(
	parameter int FILT = 8
) (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic raw,
	output logic      filt_out
);
	logic       s1_ff;
	logic       s2_ff;
	logic       s3_ff;
	logic [7:0] cnt_ff;

	always_ff @(posedge clk) begin
		if (rst) begin
			s1_ff <= 1'b1;
			s2_ff <= 1'b1;
			s3_ff <= 1'b1;
		end else begin
			s1_ff <= raw;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
		end
	end

	// a new level counts only while the 2nd and 3rd stages agree
	always_ff @(posedge clk) begin
		if (rst) begin
			cnt_ff   <= 8'h00;
			filt_out <= 1'b1;
		end else if (s2_ff == s3_ff && s3_ff != filt_out) begin
			if (cnt_ff >= 8'(FILT - 1)) begin
				cnt_ff   <= 8'h00;
				filt_out <= s3_ff;
			end else begin
				cnt_ff <= cnt_ff + 8'h01;
			end
		end else begin
			cnt_ff <= 8'h00;
		end
	end
endmodule : row_filter

/* hw/key_scanner.sv */
// Purpose: autonomous key matrix scanner with key-code buffer and register port
// Assumes: matrix rows pulled up, pressed key pulls its row to the low column
// Notes:   one scan position per scan tick; the tick divider runs only while scanning with SCAN_CLK_REQ or OTHER_CLK_EN
// Summary of operation
// - scan every position of 8x20 matrix
// - active column count programmable 1 to 20
// - active row count programmable 1 to 8
// - sixteen-byte key-code buffer
// - positions stepped at 128 kHz tick
// - n-key rollover, lock out ghost keys
// - codes kept until read; lost on overflow
// - rows synchronised, filtered and debounced
// - scan clock stops when no key pressed
// - reset to idle, all columns high
// - idle row change starts scan, requests clock unless OTHER_CLK_EN
// - idle clears row-hit and key index
// - row counter wraps, then column advances
// - both terminal counts lead to scan-end
// - key index counts positions, is the buffered code
// - row-hit ORs columns with two+ hits
// - key on already-hit row sets ghost
// - scan-end rescans if any key seen
// - no key: idle and drop clock request
//
// Chosen here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/10ps
`include "key_scan_map.svh"
module key_scanner
	import key_scan_pkg::*;
#(
	parameter int ROWS      = 8,
	parameter int COLS      = 20,
	parameter int DEPTH     = 16,
	parameter int SCAN_DIV  = `KS_SCAN_DIV,
	parameter int FILT      = `KS_FILTER_CYC
) (
	input  wire logic             SYS_CLK,
	input  wire logic             RST,
	input  wire logic [ROWS-1:0]  ROW_N,
	input  wire logic             OTHER_CLK_EN,
	input  wire logic [7:0]       ADDR,
	input  wire logic [31:0]      WDATA,
	input  wire logic             WR,
	input  wire logic             RD,
	output logic      [31:0]      RDATA,
	output logic      [COLS-1:0]  COL_N,
	output logic                  SCAN_CLK_REQ
);
	localparam int NKEYS = ROWS * COLS;

	scan_state_t      state_ff;
	scan_state_t      nxt_state;
	logic [ROWS-1:0]  row_filt;
	logic [ROWS-1:0]  row_prev_ff;
	logic             en_ff;
	logic [4:0]       ncols_ff;
	logic [3:0]       nrows_ff;
	logic [7:0]       div_ff;
	logic             tick;
	logic [2:0]       row_ff;
	logic [4:0]       col_ff;
	logic [7:0]       key_idx_ff;
	logic [7:0]       row_hit_ff;
	logic [7:0]       col_rows_ff;
	logic [7:0]       col_hits;
	logic             any_key_ff;
	logic             last_row;
	logic             last_col;
	logic             pressed;
	logic             ghost_now;
	logic [NKEYS-1:0] held_ff;
	logic             push;
	logic             pop;
	logic             ghost_ff;
	logic             ovf_ff;
	logic [7:0]       fifo_mem [DEPTH];
	logic [3:0]       wr_ptr_ff;
	logic [3:0]       rd_ptr_ff;
	logic [4:0]       count_ff;
	logic             fifo_full;
	logic             fifo_empty;
	logic             wr_ctrl;
	logic             wr_status;

	// per-row synchroniser and glitch filter
	genvar gi;
	generate
		for (gi = 0; gi < ROWS; gi++) begin : g_row
			row_filter #(
				.FILT     (FILT)
			) u_filt (
				.clk      (SYS_CLK),
				.rst      (RST),
				.raw      (ROW_N[gi]),
				.filt_out (row_filt[gi])
			);
		end
	endgenerate

	// ---------------- register port ----------------
	assign wr_ctrl   = WR && ADDR == `KS_OFF_CTRL;
	assign wr_status = WR && ADDR == `KS_OFF_STATUS;
	assign pop       = RD && ADDR == `KS_OFF_KEY && !fifo_empty;

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			en_ff <= `KS_RST_EN;
		end else if (wr_ctrl) begin
			en_ff <= WDATA[`KS_CTRL_EN_BIT];
		end
	end

	// out-of-range counts are clamped so the terminal compare is always reached
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			ncols_ff <= `KS_RST_COLS;
		end else if (wr_ctrl) begin
			if (WDATA[`KS_CTRL_COLS_MSB:`KS_CTRL_COLS_LSB] == 5'h00) begin
				ncols_ff <= 5'h01;
			end else if (WDATA[`KS_CTRL_COLS_MSB:`KS_CTRL_COLS_LSB] > `KS_MAX_COLS) begin
				ncols_ff <= `KS_MAX_COLS;
			end else begin
				ncols_ff <= WDATA[`KS_CTRL_COLS_MSB:`KS_CTRL_COLS_LSB];
			end
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			nrows_ff <= `KS_RST_ROWS;
		end else if (wr_ctrl) begin
			if (WDATA[`KS_CTRL_ROWS_MSB:`KS_CTRL_ROWS_LSB] == 4'h0) begin
				nrows_ff <= 4'h1;
			end else if (WDATA[`KS_CTRL_ROWS_MSB:`KS_CTRL_ROWS_LSB] > `KS_MAX_ROWS) begin
				nrows_ff <= `KS_MAX_ROWS;
			end else begin
				nrows_ff <= WDATA[`KS_CTRL_ROWS_MSB:`KS_CTRL_ROWS_LSB];
			end
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			RDATA <= 32'h0000_0000;
		end else if (RD) begin
			RDATA <= 32'h0000_0000;
			unique case (ADDR)
				`KS_OFF_CTRL: begin
					RDATA[`KS_CTRL_EN_BIT] <= en_ff;
					RDATA[`KS_CTRL_COLS_MSB:`KS_CTRL_COLS_LSB] <= ncols_ff;
					RDATA[`KS_CTRL_ROWS_MSB:`KS_CTRL_ROWS_LSB] <= nrows_ff;
				end
				`KS_OFF_STATUS: begin
					RDATA[`KS_ST_GHOST_BIT] <= ghost_ff;
					RDATA[`KS_ST_OVF_BIT]   <= ovf_ff;
					RDATA[`KS_ST_AVAIL_BIT] <= !fifo_empty;
					RDATA[`KS_ST_REQ_BIT]   <= SCAN_CLK_REQ;
					RDATA[`KS_ST_CNT_MSB:`KS_ST_CNT_LSB] <= count_ff;
				end
				`KS_OFF_KEY: begin
					RDATA[`KS_KEY_VALID_BIT] <= !fifo_empty;
					RDATA[7:0] <= fifo_empty ? 8'h00 : fifo_mem[rd_ptr_ff];
				end
				default: begin
					RDATA <= 32'h0000_0000;
				end
			endcase
		end else begin
			RDATA <= 32'h0000_0000;
		end
	end

	// ---------------- scan timing ----------------
	// restarts with each pass so row 0 waits for the filters; stands still without SCAN_CLK_REQ or OTHER_CLK_EN
	always_ff @(posedge SYS_CLK) begin
		if (RST || state_ff != ST_SCAN || (!SCAN_CLK_REQ && !OTHER_CLK_EN)) begin
			div_ff <= 8'h00;
		end else if (div_ff >= 8'(SCAN_DIV - 1)) begin
			div_ff <= 8'h00;
		end else begin
			div_ff <= div_ff + 8'h01;
		end
	end
	assign tick = (SCAN_CLK_REQ || OTHER_CLK_EN) && div_ff >= 8'(SCAN_DIV - 1);

	// ---------------- scan sequencing ----------------
	assign last_row  = {1'b0, row_ff} == 4'(nrows_ff - 4'h1);
	assign last_col  = col_ff == 5'(ncols_ff - 5'h01);
	assign pressed   = !row_filt[row_ff];
	assign ghost_now = pressed && row_hit_ff[row_ff];
	assign col_hits  = col_rows_ff | (pressed ? 8'(8'h01 << row_ff) : 8'h00);

	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			ST_IDLE: begin
				if (en_ff && row_filt != row_prev_ff) begin
					nxt_state = ST_SCAN;
				end
			end
			ST_SCAN: begin
				if (tick && last_row && last_col) begin
					nxt_state = ST_SCAN_END;
				end
			end
			ST_SCAN_END: begin
				if (any_key_ff && en_ff) begin
					nxt_state = ST_SCAN;
				end else begin
					nxt_state = ST_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			state_ff <= ST_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			row_prev_ff <= '1;
		end else begin
			row_prev_ff <= row_filt;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			SCAN_CLK_REQ <= 1'b0;
		end else if (state_ff == ST_IDLE && nxt_state == ST_SCAN) begin
			SCAN_CLK_REQ <= !OTHER_CLK_EN;
		end else if (nxt_state == ST_IDLE) begin
			SCAN_CLK_REQ <= 1'b0;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (RST || nxt_state != ST_SCAN || state_ff != ST_SCAN) begin
			COL_N <= '1;
		end else begin
			COL_N <= ~(COLS'(1) << col_ff);
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (RST || state_ff != ST_SCAN) begin
			row_ff <= 3'h0;
			col_ff <= 5'h00;
		end else if (tick) begin
			if (last_row) begin
				row_ff <= 3'h0;
				col_ff <= col_ff + 5'h01;
			end else begin
				row_ff <= row_ff + 3'h1;
			end
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (RST || state_ff != ST_SCAN) begin
			key_idx_ff <= 8'h00;
		end else if (tick) begin
			key_idx_ff <= key_idx_ff + 8'h01;
		end
	end

	// a column with one hit cannot cause a ghost, so only multi-hit columns are merged
	always_ff @(posedge SYS_CLK) begin
		if (RST || state_ff != ST_SCAN) begin
			row_hit_ff  <= 8'h00;
			col_rows_ff <= 8'h00;
		end else if (tick) begin
			if (last_row) begin
				col_rows_ff <= 8'h00;
				if ((col_hits & (col_hits - 8'h01)) != 8'h00) begin
					row_hit_ff <= row_hit_ff | col_hits;
				end
			end else begin
				col_rows_ff <= col_hits;
			end
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (RST || state_ff == ST_IDLE) begin
			any_key_ff <= 1'b0;
		end else if (state_ff == ST_SCAN_END) begin
			any_key_ff <= 1'b0;
		end else if (tick && pressed) begin
			any_key_ff <= 1'b1;
		end
	end

	// a ghost key keeps its old held state so it reports once the ambiguity clears
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			held_ff <= '0;
		end else if (state_ff == ST_SCAN && tick && !ghost_now) begin
			held_ff[key_idx_ff] <= pressed;
		end
	end

	// only a new press of an unambiguous key enters the buffer
	assign push = state_ff == ST_SCAN && tick && pressed && !ghost_now
		&& !held_ff[key_idx_ff];

	// hardware set wins over software clear
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			ghost_ff <= 1'b0;
		end else if (state_ff == ST_SCAN && tick && ghost_now) begin
			ghost_ff <= 1'b1;
		end else if (wr_status && WDATA[`KS_ST_GHOST_BIT]) begin
			ghost_ff <= 1'b0;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			ovf_ff <= 1'b0;
		end else if (push && fifo_full && !pop) begin
			ovf_ff <= 1'b1;
		end else if (wr_status && WDATA[`KS_ST_OVF_BIT]) begin
			ovf_ff <= 1'b0;
		end
	end

	// ---------------- key-code buffer ----------------
	assign fifo_full  = count_ff == 5'(DEPTH);
	assign fifo_empty = count_ff == 5'h00;

	always_ff @(posedge SYS_CLK) begin
		if (push && (!fifo_full || pop)) begin
			fifo_mem[wr_ptr_ff] <= key_idx_ff;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			wr_ptr_ff <= 4'h0;
		end else if (push && (!fifo_full || pop)) begin
			wr_ptr_ff <= wr_ptr_ff + 4'h1;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			rd_ptr_ff <= 4'h0;
		end else if (pop) begin
			rd_ptr_ff <= rd_ptr_ff + 4'h1;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			count_ff <= 5'h00;
		end else if (push && !fifo_full && !pop) begin
			count_ff <= count_ff + 5'h01;
		end else if (pop && !push) begin
			count_ff <= count_ff - 5'h01;
		end
	end
endmodule : key_scanner

/* verif/key_scanner_checker.sv */
// Purpose: port checker of the key scanner
// Assumes: scan tick of at least 4 cycles
// Notes:   bound to every key_scanner instance
`timescale 1ns/10ps
`include "key_scan_map.svh"
module key_scanner_checker #(
	parameter int COLS = 20
) (
	input wire logic            SYS_CLK,
	input wire logic            RST,
	input wire logic            OTHER_CLK_EN,
	input wire logic [7:0]      ADDR,
	input wire logic            RD,
	input wire logic [31:0]     RDATA,
	input wire logic [COLS-1:0] COL_N,
	input wire logic            SCAN_CLK_REQ
);
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (RST);
	sequence s_st_rd; RD && ADDR == `KS_OFF_STATUS; endsequence
	sequence s_key_rd; RD && ADDR == `KS_OFF_KEY; endsequence
	sequence s_new_col; $changed(COL_N) && !(&COL_N); endsequence
	chk_reset_idle: assert property ($fell(RST) |-> &COL_N && !SCAN_CLK_REQ)
		else $error("outputs not idle after reset");
	chk_one_col: assert property ($countones(~COL_N) <= 1)
		else $error("more than one column low");
	chk_col_hold: assert property (s_new_col |=> $stable(COL_N)[*3])
		else $error("column left before its tick");
	chk_col_step: assert property (s_new_col and !(&$past(COL_N)) |->
		~COL_N == (~$past(COL_N)) << 1)
		else $error("column did not advance by one");
	chk_scan_start: assert property ($rose(SCAN_CLK_REQ) |->
		##[0:1] COL_N == {{(COLS-1){1'b1}}, 1'b0})
		else $error("scan did not start on column zero");
	chk_idle_cols: assert property (!SCAN_CLK_REQ && !$past(SCAN_CLK_REQ) && !OTHER_CLK_EN
		|-> &COL_N)
		else $error("columns driven without clock request");
	chk_req_drop: assert property ($fell(SCAN_CLK_REQ) |-> &COL_N)
		else $error("request dropped while scanning");
	chk_rd_quiet: assert property (!$past(RD) |-> RDATA == 32'h0)
		else $error("read data outside read answer");
	chk_key_fmt: assert property (s_key_rd |=> RDATA[31:9] == 23'h0
		&& (RDATA[8] || RDATA[7:0] == 8'h0))
		else $error("key word malformed");
	chk_st_count: assert property (s_st_rd |=> RDATA[12:8] <= 5'h10
		&& RDATA[2] == (RDATA[12:8] != 5'h0))
		else $error("entry count or available flag wrong");
endmodule : key_scanner_checker
bind key_scanner key_scanner_checker #(.COLS(COLS)) key_scanner_checker_inst (
	.SYS_CLK, .RST, .OTHER_CLK_EN, .ADDR, .RD, .RDATA, .COL_N, .SCAN_CLK_REQ);

/* verif/key_matrix.sv */
// Purpose: passive switch matrix behind the key scanner
// Assumes: rows pulled up, a closed switch ties its row to its column
// Notes:   wake pulls rows 7..4 low, outside the scanned rows, to start a scan
`timescale 1ns/10ps
module key_matrix (
	input  wire logic [19:0]      col_n,
	input  wire logic [19:0][7:0] press,
	input  wire logic             wake,
	output logic      [7:0]       row_n
);
	always_comb begin
		row_n = 8'hff;
		for (int c = 0; c < 20; c++) begin
			for (int r = 0; r < 8; r++) begin
				if (press[c][r] && !col_n[c]) begin
					row_n[r] = 1'b0;
				end
			end
		end
		if (wake) begin
			row_n[7:4] = 4'h0;
		end
	end
endmodule : key_matrix

/* verif/testbench.sv */
// Purpose: self-checking bench of the key scanner
// Assumes: tick of 8 cycles and filter of 2 keep scans short
// Notes:   key code is column times rows plus row
`timescale 1ns/10ps
`include "key_scan_map.svh"
module testbench;
	logic             SYS_CLK = 1'b0;
	logic             RST = 1'b1;
	logic             OTHER_CLK_EN = 1'b0;
	logic [7:0]       ADDR = 8'h00;
	logic [31:0]      WDATA = 32'h0;
	logic             WR = 1'b0;
	logic             RD = 1'b0;
	logic [31:0]      RDATA;
	logic [19:0]      COL_N;
	logic             SCAN_CLK_REQ;
	logic [7:0]       ROW_N;
	logic [19:0][7:0] press = '0;
	logic             wake = 1'b0;
	int               errors = 0;
	int               cmp_count = 0;
	always #20 SYS_CLK = ~SYS_CLK;
	key_scanner #(.SCAN_DIV(8), .FILT(2)) key_scanner_inst (.SYS_CLK, .RST, .ROW_N,
		.OTHER_CLK_EN, .ADDR, .WDATA, .WR, .RD, .RDATA, .COL_N, .SCAN_CLK_REQ);
	key_matrix key_matrix_inst (.col_n(COL_N), .press(press), .wake(wake), .row_n(ROW_N));
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : check
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge SYS_CLK);
		ADDR <= a;
		WDATA <= d;
		WR <= 1'b1;
		@(posedge SYS_CLK);
		WR <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge SYS_CLK);
		ADDR <= a;
		RD <= 1'b1;
		@(posedge SYS_CLK);
		RD <= 1'b0;
		#1 check(RDATA, e);
	endtask : rd
	task automatic wait_req(input logic v);
		int n = 0;
		while (SCAN_CLK_REQ !== v && n < 400) begin
			@(posedge SYS_CLK);
			n++;
		end
		check({31'h0, SCAN_CLK_REQ}, {31'h0, v});
	endtask : wait_req
	task automatic poke;
		@(posedge SYS_CLK);
		wake <= 1'b1;
		repeat (8) @(posedge SYS_CLK);
		wake <= 1'b0;
	endtask : poke
	task automatic end_of_test;
		$display("errors %0d compares %0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : end_of_test
	// a hang is cut short long after the whole run should be done
	initial begin
		repeat (20000) @(posedge SYS_CLK);
		errors++;
		end_of_test;
	end
	initial begin
		repeat (10) @(posedge SYS_CLK);
		RST <= 1'b0;
		rd(`KS_OFF_CTRL, 32'h0008_1400);
		rd(`KS_OFF_STATUS, 32'h0);
		rd(8'h0c, 32'h0);
		check(32'(COL_N), 32'h000f_ffff);
		wr(`KS_OFF_CTRL, 32'h0);
		rd(`KS_OFF_CTRL, 32'h0001_0100);
		wr(`KS_OFF_CTRL, 32'h000f_1f00);
		rd(`KS_OFF_CTRL, 32'h0008_1400);
		// disabled: a row change must not start a scan
		press[1][2] <= 1'b1;
		poke;
		repeat (60) @(posedge SYS_CLK);
		check({31'h0, SCAN_CLK_REQ}, 32'h0);
		press <= '0;
		wr(`KS_OFF_CTRL, 32'h0004_0301);
		rd(`KS_OFF_CTRL, 32'h0004_0301);
		press[1][2] <= 1'b1;
		poke;
		wait_req(1'b1);
		repeat (150) @(posedge SYS_CLK);
		rd(`KS_OFF_STATUS, 32'h0000_010c);
		rd(`KS_OFF_KEY, 32'h0000_0106);
		rd(`KS_OFF_KEY, 32'h0);
		press <= '0;
		wait_req(1'b0);
		check(32'(COL_N), 32'h000f_ffff);
		// one held key keeps the scan alive while another is tapped 16 times
		press[0][0] <= 1'b1;
		poke;
		wait_req(1'b1);
		for (int i = 0; i < 16; i++) begin
			press[1][1] <= 1'b1;
			repeat (120) @(posedge SYS_CLK);
			press[1][1] <= 1'b0;
			repeat (120) @(posedge SYS_CLK);
		end
		rd(`KS_OFF_STATUS, 32'h0000_100e);
		press <= '0;
		wait_req(1'b0);
		rd(`KS_OFF_KEY, 32'h0000_0100);
		for (int i = 0; i < 15; i++) begin
			rd(`KS_OFF_KEY, 32'h0000_0105);
		end
		rd(`KS_OFF_KEY, 32'h0);
		wr(`KS_OFF_STATUS, 32'h2);
		rd(`KS_OFF_STATUS, 32'h0);
		// square of four keys: column 1 pair is ambiguous, clock run by another user
		OTHER_CLK_EN <= 1'b1;
		press[0][0] <= 1'b1;
		press[0][1] <= 1'b1;
		press[1][0] <= 1'b1;
		press[1][1] <= 1'b1;
		poke;
		repeat (300) @(posedge SYS_CLK);
		rd(`KS_OFF_STATUS, 32'h0000_0205);
		rd(`KS_OFF_KEY, 32'h0000_0100);
		rd(`KS_OFF_KEY, 32'h0000_0101);
		press <= '0;
		repeat (300) @(posedge SYS_CLK);
		check(32'(COL_N), 32'h000f_ffff);
		wr(`KS_OFF_STATUS, 32'h1);
		rd(`KS_OFF_STATUS, 32'h0);
		end_of_test;
	end
endmodule : testbench
